//--- design/pin_mux_params.svh
// Constants for the shared pin function multiplexer: offsets, fields, resets, widths.
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define REG_PERIPH_CFG     8'h00
`define REG_GPIO_ENABLE    8'h04
`define REG_GPIO_DIRECTION 8'h08
`define REG_GPIO_OUT       8'h0C
`define REG_GPIO_IN        8'h10
`define REG_STATUS         8'h14

// ************************************************************
// Field positions
// ************************************************************
`define CFG_AUDIO0_BIT     0
`define CFG_VIDEO1_BIT     1
`define CFG_SERIAL1_BIT    2
`define STAT_PCI_BIT       0
`define STAT_ETH_BIT       1
`define STAT_UP_OWN_LSB    2
`define STAT_LO_OWN_LSB    4
`define GP_CLK4_BIT        1
`define GP_CLK6_BIT        2
`define GP_VCXO_DAC_OUTPUT_BIT        8
`define GP_PCI_LO          9
`define GP_PCI_HI          15

// ************************************************************
// Widths and reset values
// ************************************************************
`define GP_W               16
`define GP_PCI_W           7
`define UP_W               8
`define LO_W               7
`define PCI_SOLO_W         8
`define CFG_W              3
`define CFG_RESET          3'h4
`define GP_RESET           16'h0000

`endif

//--- design/pin_mux_pkg.sv
// Types shared by the shared pin function multiplexer.
`include "pin_mux_params.svh"

package pin_mux_pkg;

    typedef enum logic [1:0] {
        OWN_NONE   = 2'b00,
        OWN_VIDEO  = 2'b01,
        OWN_AUDIO  = 2'b10,
        OWN_SERIAL = 2'b11
    } owner_t;

    typedef struct packed {
        logic                act;
        logic                done;
        logic [7:0]          addr;
        logic                wr;
        logic [31:0]         rdata;
        logic [`CFG_W-1:0]   periph_cfg;
        logic [`GP_W-1:0]    gp_en;
        logic [`GP_W-1:0]    gp_dir;
        logic [`GP_W-1:0]    gp_out;
        logic [`GP_W-1:0]    gp_in;
        logic                pci_strap;
        logic                eth_strap;
    } mux_state_t;

endpackage

//--- design/shared_pin_function_mux.sv
// Shared pin function multiplexer with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "pin_mux_params.svh"
// How it works
// - The PCI select strap is caught only while reset is held and ignored afterwards.
// - Strap-selected pins belong to exactly one peripheral, never to two at once.
// - Pins one and two drive the divided clocks until their GPIO enable bit is set.
// - An enabled GPIO pin is an input when its direction bit is 0 and an output when 1.
// - Pin eight drives the VCXO DAC unless the strap is 0 and GPIO eight is enabled.
// - GPIO nine to fifteen work only with the strap at 0, else the PCI core owns them.
// - After reset the upper video pins serve neither video nor audio.
// - The video enable bit gives the upper pins to video and keeps audio off them.
// - The audio enable bit gives the upper pins to audio data seven to zero.
// - After reset the lower video pins serve the buffered serial port.
// - With the strap at 0 the standalone PCI pins are never driven.

module shared_pin_function_mux
    import pin_mux_pkg::*;
(
    input  wire logic                   REF_CLK,
    input  wire logic                   RESET,
    input  wire logic                   HSEL,
    input  wire logic [31:0]            HADDR,
    input  wire logic [1:0]             HTRANS,
    input  wire logic                   HWRITE,
    input  wire logic [2:0]             HSIZE,
    input  wire logic [31:0]            HWDATA,
    input  wire logic                   HREADY,
    output logic [31:0]                 HRDATA,
    output logic                        HREADYOUT,
    output logic                        HRESP,
    input  wire logic                   PCI_SELECT_STRAP,
    input  wire logic                   ETHERNET_ENABLE_STRAP,
    input  wire logic                   CLOCK_OUT_DIV_FOUR,
    input  wire logic                   CLOCK_OUT_DIV_SIX,
    input  wire logic                   VCXO_DAC_OUTPUT,
    input  wire logic [`GP_W-1:0]       GPIO_PAD_I,
    output logic [`GP_W-1:0]            GPIO_PAD_O,
    output logic [`GP_W-1:0]            GPIO_PAD_OE,
    input  wire logic [`GP_PCI_W-1:0]   PCI_SHARED_O,
    input  wire logic [`GP_PCI_W-1:0]   PCI_SHARED_OE,
    output logic [`GP_PCI_W-1:0]        PCI_SHARED_I,
    input  wire logic [`PCI_SOLO_W-1:0] PCI_SOLO_CORE_O,
    input  wire logic [`PCI_SOLO_W-1:0] PCI_SOLO_CORE_OE,
    output logic [`PCI_SOLO_W-1:0]      PCI_SOLO_PAD_O,
    output logic [`PCI_SOLO_W-1:0]      PCI_SOLO_PAD_OE,
    input  wire logic [`UP_W-1:0]       VIDEO_PORT1_DATA_UP_O,
    input  wire logic [`UP_W-1:0]       VIDEO_PORT1_DATA_UP_OE,
    output logic [`UP_W-1:0]            VIDEO_PORT1_DATA_UP_I,
    input  wire logic [`UP_W-1:0]       AUDIO_SERIAL0_DATA_O,
    input  wire logic [`UP_W-1:0]       AUDIO_SERIAL0_DATA_OE,
    output logic [`UP_W-1:0]            AUDIO_SERIAL0_DATA_I,
    input  wire logic [`UP_W-1:0]       UPPER_PAD_I,
    output logic [`UP_W-1:0]            UPPER_PAD_O,
    output logic [`UP_W-1:0]            UPPER_PAD_OE,
    input  wire logic [`LO_W-1:0]       VIDEO_PORT1_DATA_LO_O,
    input  wire logic [`LO_W-1:0]       VIDEO_PORT1_DATA_LO_OE,
    output logic [`LO_W-1:0]            VIDEO_PORT1_DATA_LO_I,
    input  wire logic [`LO_W-1:0]       BUFFERED_SERIAL1_O,
    input  wire logic [`LO_W-1:0]       BUFFERED_SERIAL1_OE,
    output logic [`LO_W-1:0]            BUFFERED_SERIAL1_I,
    input  wire logic [`LO_W-1:0]       LOWER_PAD_I,
    output logic [`LO_W-1:0]            LOWER_PAD_O,
    output logic [`LO_W-1:0]            LOWER_PAD_OE,
    output logic                        VIDEO_UPPER_SELECTED,
    output logic                        AUDIO_SELECTED,
    output logic                        VIDEO_LOWER_SELECTED,
    output logic                        SERIAL_SELECTED
);

    // ************************************************************
    // Owner decoding
    // ************************************************************
    // Video wins when software sets both enables; the pins must never have two drivers.
    function automatic owner_t pick_owner(input logic video_en, input logic alt_en,
                                          input owner_t alt_owner);
        if (video_en) begin
            return OWN_VIDEO;
        end else if (alt_en) begin
            return alt_owner;
        end
        return OWN_NONE;
    endfunction

    localparam mux_state_t ST_RESET = '{
        act:        1'b0,
        done:       1'b0,
        addr:       8'h00,
        wr:         1'b0,
        rdata:      32'h0000_0000,
        periph_cfg: `CFG_RESET,
        gp_en:      `GP_RESET,
        gp_dir:     `GP_RESET,
        gp_out:     `GP_RESET,
        gp_in:      `GP_RESET,
        pci_strap:  1'b0,
        eth_strap:  1'b0
    };

    mux_state_t st_r;
    mux_state_t st_nxt;
    owner_t     upper_owner;
    owner_t     lower_owner;
    logic       video1_en;
    logic       audio0_en;
    logic       serial1_en;
    logic [`GP_W-1:0] gpio_mode;

    assign video1_en  = st_r.periph_cfg[`CFG_VIDEO1_BIT];
    assign audio0_en  = st_r.periph_cfg[`CFG_AUDIO0_BIT];
    assign serial1_en = st_r.periph_cfg[`CFG_SERIAL1_BIT];
    assign upper_owner = pick_owner(video1_en, audio0_en, OWN_AUDIO);
    assign lower_owner = pick_owner(video1_en, serial1_en, OWN_SERIAL);

    // ************************************************************
    // Register slave and state
    // ************************************************************
    // Every transfer takes one wait state so that read data comes straight from a flop.
    assign HREADYOUT = !(st_r.act && !st_r.done);
    assign HRESP     = 1'b0;
    assign HRDATA    = st_r.rdata;

    always_comb begin
        st_nxt = st_r;
        st_nxt.gp_in = GPIO_PAD_I;
        if (st_r.act && !st_r.done) begin
            st_nxt.done = 1'b1;
            unique case (st_r.addr)
                `REG_PERIPH_CFG:     st_nxt.rdata = {29'h0, st_r.periph_cfg};
                `REG_GPIO_ENABLE:    st_nxt.rdata = {16'h0, st_r.gp_en};
                `REG_GPIO_DIRECTION: st_nxt.rdata = {16'h0, st_r.gp_dir};
                `REG_GPIO_OUT:       st_nxt.rdata = {16'h0, st_r.gp_out};
                `REG_GPIO_IN:        st_nxt.rdata = {16'h0, st_r.gp_in & gpio_mode};
                `REG_STATUS:         st_nxt.rdata = {26'h0, lower_owner, upper_owner,
                                                     st_r.eth_strap, st_r.pci_strap};
                default:             st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // Selection bits are not locked; a later write moves the pins on the next cycle.
        // Software selects once after reset; swapping owners mid-transfer glitches both sides.
        if (st_r.act && st_r.done) begin
            st_nxt.act = 1'b0;
            if (st_r.wr) begin
                unique case (st_r.addr)
                    `REG_PERIPH_CFG:     st_nxt.periph_cfg = HWDATA[`CFG_W-1:0];
                    `REG_GPIO_ENABLE:    st_nxt.gp_en = HWDATA[`GP_W-1:0];
                    `REG_GPIO_DIRECTION: st_nxt.gp_dir = HWDATA[`GP_W-1:0];
                    `REG_GPIO_OUT:       st_nxt.gp_out = HWDATA[`GP_W-1:0];
                    default:             st_nxt.act = 1'b0;
                endcase
            end
        end
        if (HSEL && HTRANS[1] && HREADY) begin
            st_nxt.act  = 1'b1;
            st_nxt.done = 1'b0;
            st_nxt.addr = HADDR[7:0];
            st_nxt.wr   = HWRITE;
        end
        // Straps are followed only while reset is held; the last value before release stays.
        if (RESET) begin
            st_nxt           = ST_RESET;
            st_nxt.pci_strap = PCI_SELECT_STRAP;
            st_nxt.eth_strap = ETHERNET_ENABLE_STRAP;
        end
    end

    always_ff @(posedge REF_CLK) begin
        st_r <= st_nxt;
    end

    // ************************************************************
    // GPIO bank zero pads
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `GP_W; gi++) begin : g_gp
            logic alt_o;
            logic alt_oe;
            if (gi == `GP_CLK4_BIT) begin : g_c4
                assign gpio_mode[gi] = st_r.gp_en[gi];
                assign alt_o  = CLOCK_OUT_DIV_FOUR;
                assign alt_oe = 1'b1;
            end else if (gi == `GP_CLK6_BIT) begin : g_c6
                assign gpio_mode[gi] = st_r.gp_en[gi];
                assign alt_o  = CLOCK_OUT_DIV_SIX;
                assign alt_oe = 1'b1;
            end else if (gi == `GP_VCXO_DAC_OUTPUT_BIT) begin : g_dac
                assign gpio_mode[gi] = st_r.gp_en[gi] && !st_r.pci_strap;
                assign alt_o  = VCXO_DAC_OUTPUT;
                assign alt_oe = 1'b1;
            end else if (gi >= `GP_PCI_LO) begin : g_pci
                assign gpio_mode[gi] = st_r.gp_en[gi] && !st_r.pci_strap;
                assign alt_o  = st_r.pci_strap && PCI_SHARED_O[gi-`GP_PCI_LO];
                assign alt_oe = st_r.pci_strap && PCI_SHARED_OE[gi-`GP_PCI_LO];
            end else begin : g_plain
                assign gpio_mode[gi] = st_r.gp_en[gi];
                assign alt_o  = 1'b0;
                assign alt_oe = 1'b0;
            end
            assign GPIO_PAD_O[gi]  = gpio_mode[gi] ? st_r.gp_out[gi] : alt_o;
            assign GPIO_PAD_OE[gi] = gpio_mode[gi] ? st_r.gp_dir[gi] : alt_oe;
        end
    endgenerate

    assign PCI_SHARED_I = st_r.pci_strap ? GPIO_PAD_I[`GP_PCI_HI:`GP_PCI_LO] : '0;

    // ************************************************************
    // Standalone PCI pins
    // ************************************************************
    assign PCI_SOLO_PAD_O  = st_r.pci_strap ? PCI_SOLO_CORE_O : '0;
    assign PCI_SOLO_PAD_OE = st_r.pci_strap ? PCI_SOLO_CORE_OE : '0;

    // ************************************************************
    // Video port one pads
    // ************************************************************
    always_comb begin
        UPPER_PAD_O  = '0;
        UPPER_PAD_OE = '0;
        unique case (upper_owner)
            OWN_VIDEO: begin
                UPPER_PAD_O  = VIDEO_PORT1_DATA_UP_O;
                UPPER_PAD_OE = VIDEO_PORT1_DATA_UP_OE;
            end
            OWN_AUDIO: begin
                UPPER_PAD_O  = AUDIO_SERIAL0_DATA_O;
                UPPER_PAD_OE = AUDIO_SERIAL0_DATA_OE;
            end
            default: begin
                UPPER_PAD_O  = '0;
                UPPER_PAD_OE = '0;
            end
        endcase
        LOWER_PAD_O  = '0;
        LOWER_PAD_OE = '0;
        unique case (lower_owner)
            OWN_VIDEO: begin
                LOWER_PAD_O  = VIDEO_PORT1_DATA_LO_O;
                LOWER_PAD_OE = VIDEO_PORT1_DATA_LO_OE;
            end
            OWN_SERIAL: begin
                LOWER_PAD_O  = BUFFERED_SERIAL1_O;
                LOWER_PAD_OE = BUFFERED_SERIAL1_OE;
            end
            default: begin
                LOWER_PAD_O  = '0;
                LOWER_PAD_OE = '0;
            end
        endcase
    end

    // A deselected function sees zeros, so it cannot act on another port's traffic.
    assign VIDEO_UPPER_SELECTED  = (upper_owner == OWN_VIDEO);
    assign AUDIO_SELECTED        = (upper_owner == OWN_AUDIO);
    assign VIDEO_LOWER_SELECTED  = (lower_owner == OWN_VIDEO);
    assign SERIAL_SELECTED       = (lower_owner == OWN_SERIAL);
    assign VIDEO_PORT1_DATA_UP_I = VIDEO_UPPER_SELECTED ? UPPER_PAD_I : '0;
    assign AUDIO_SERIAL0_DATA_I  = AUDIO_SELECTED ? UPPER_PAD_I : '0;
    assign VIDEO_PORT1_DATA_LO_I = VIDEO_LOWER_SELECTED ? LOWER_PAD_I : '0;
    assign BUFFERED_SERIAL1_I    = SERIAL_SELECTED ? LOWER_PAD_I : '0;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_STRAP_FROZEN: assert property (@(posedge REF_CLK) disable iff (RESET)
        !$past(RESET) |-> $stable(st_r.pci_strap))
        else $error("PCI strap changed outside reset.");

    AST_PCI_SHARED_OWNER: assert property (@(posedge REF_CLK) disable iff (RESET)
        st_r.pci_strap |-> (GPIO_PAD_OE[`GP_PCI_HI:`GP_PCI_LO] == PCI_SHARED_OE)
                           && (PCI_SHARED_I == GPIO_PAD_I[`GP_PCI_HI:`GP_PCI_LO]))
        else $error("Shared PCI pins not owned by the PCI core.");

    AST_CLOCK_DEFAULT: assert property (@(posedge REF_CLK) disable iff (RESET)
        !st_r.gp_en[`GP_CLK4_BIT] |-> GPIO_PAD_OE[`GP_CLK4_BIT]
                                       && (GPIO_PAD_O[`GP_CLK4_BIT] == CLOCK_OUT_DIV_FOUR))
        else $error("Divide-by-four clock not on its pin.");

    AST_GPIO_DIRECTION: assert property (@(posedge REF_CLK) disable iff (RESET)
        st_r.gp_en[`GP_CLK6_BIT] |-> (GPIO_PAD_OE[`GP_CLK6_BIT] == st_r.gp_dir[`GP_CLK6_BIT]))
        else $error("GPIO direction not honoured.");

    AST_VCXO_DAC_OUTPUT_STRAP: assert property (@(posedge REF_CLK) disable iff (RESET)
        st_r.pci_strap |-> GPIO_PAD_OE[`GP_VCXO_DAC_OUTPUT_BIT]
                           && (GPIO_PAD_O[`GP_VCXO_DAC_OUTPUT_BIT] == VCXO_DAC_OUTPUT))
        else $error("VCXO DAC pin taken by GPIO while PCI is strapped.");

    AST_GPIO_PCI_IDLE: assert property (@(posedge REF_CLK) disable iff (RESET)
        (!st_r.pci_strap && !st_r.gp_en[`GP_PCI_LO]) |-> !GPIO_PAD_OE[`GP_PCI_LO])
        else $error("Unenabled shared PCI GPIO pin is driven.");

    AST_UPPER_AFTER_RESET: assert property (@(posedge REF_CLK)
        $fell(RESET) |-> (UPPER_PAD_OE == '0) && !VIDEO_UPPER_SELECTED && !AUDIO_SELECTED)
        else $error("Upper video pins active after reset.");

    AST_VIDEO_EXCLUSIVE: assert property (@(posedge REF_CLK) disable iff (RESET)
        video1_en |-> VIDEO_UPPER_SELECTED && !AUDIO_SELECTED
                      && (AUDIO_SERIAL0_DATA_I == '0))
        else $error("Audio still on pins owned by video.");

    AST_AUDIO_OWNS: assert property (@(posedge REF_CLK) disable iff (RESET)
        (audio0_en && !video1_en) |-> (UPPER_PAD_OE == AUDIO_SERIAL0_DATA_OE)
                                      && (VIDEO_PORT1_DATA_UP_I == '0))
        else $error("Audio enable did not take the upper pins.");

    AST_SERIAL_DEFAULT: assert property (@(posedge REF_CLK)
        $fell(RESET) |-> SERIAL_SELECTED && (LOWER_PAD_OE == BUFFERED_SERIAL1_OE))
        else $error("Buffered serial port not selected after reset.");

    AST_PCI_SOLO_HIZ: assert property (@(posedge REF_CLK) disable iff (RESET)
        !st_r.pci_strap |-> (PCI_SOLO_PAD_OE == '0))
        else $error("Standalone PCI pin driven with PCI strapped off.");

    AST_BUS_ONE_WAIT: assert property (@(posedge REF_CLK) disable iff (RESET)
        (HSEL && HTRANS[1] && HREADY) |=> !HREADYOUT ##1 HREADYOUT)
        else $error("Bus data phase not exactly one wait state.");

    // The strap capture check spans reset, so it has no disable clause.
    AST_STRAP_CAPTURE: assert property (@(posedge REF_CLK)
        RESET |=> (st_r.pci_strap == $past(PCI_SELECT_STRAP)))
        else $error("PCI strap not captured during reset.");

    AST_PCI_SHARED_QUIET: assert property (@(posedge REF_CLK) disable iff (RESET)
        !st_r.pci_strap |-> (PCI_SHARED_I == '0))
        else $error("PCI core sees shared pins while strapped off.");

    AST_PCI_SOLO_DRIVEN: assert property (@(posedge REF_CLK) disable iff (RESET)
        st_r.pci_strap |-> (PCI_SOLO_PAD_OE == PCI_SOLO_CORE_OE))
        else $error("Standalone PCI pins not owned by the PCI core.");

    AST_CLOCK_SIX_DEFAULT: assert property (@(posedge REF_CLK) disable iff (RESET)
        !st_r.gp_en[`GP_CLK6_BIT] |-> GPIO_PAD_OE[`GP_CLK6_BIT]
                                       && (GPIO_PAD_O[`GP_CLK6_BIT] == CLOCK_OUT_DIV_SIX))
        else $error("Divide-by-six clock not on its pin.");

    AST_GPIO_OUTPUT: assert property (@(posedge REF_CLK) disable iff (RESET)
        (st_r.gp_en[0] && st_r.gp_dir[0]) |-> GPIO_PAD_OE[0]
                                            && (GPIO_PAD_O[0] == st_r.gp_out[0]))
        else $error("Enabled output GPIO pin not driven from its data bit.");

    AST_LOWER_VIDEO: assert property (@(posedge REF_CLK) disable iff (RESET)
        video1_en |-> VIDEO_LOWER_SELECTED && (LOWER_PAD_OE == VIDEO_PORT1_DATA_LO_OE)
                      && (BUFFERED_SERIAL1_I == '0))
        else $error("Video enable did not take the lower pins.");

endmodule // shared_pin_function_mux

//--- testbench/tb_top.sv
// Self-checking testbench for the shared pin function multiplexer.
`timescale 1ns/1ps
`include "pin_mux_params.svh"

module tb_top
    import pin_mux_pkg::*;
;
    // ************************************************************
    // Stimulus, observation and reference state
    // ************************************************************
    typedef struct packed {
        logic        clk4, clk6, dac;
        logic [15:0] gpi;
        logic [6:0]  pso, psoe;
        logic [7:0]  pco, pcoe, vuo, vuoe, auo, auoe, upi;
        logic [6:0]  vlo, vloe, sro, sroe, loi;
    } pins_t;

    logic        clk, rst, hsel, hwrite, strap, eth, hreadyout, hresp;
    logic        sel_vu, sel_au, sel_vl, sel_sr, m_strap, m_eth;
    logic        rd_ph = 1'b0;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [15:0] gpo, gpoe, m_en, m_dir, m_out;
    logic [6:0]  pci_i, vlo_i, ser_i, lo_o, lo_oe;
    logic [7:0]  solo_o, solo_oe, vup_i, aud_i, up_o, up_oe;
    logic [2:0]  probe, m_cfg;
    logic [3:0]  spare;
    pins_t       pi;
    logic [31:0] exq[$];
    int          error_cnt = 0;
    int          comparisons = 0;

    shared_pin_function_mux shared_pin_function_mux_i (
        .REF_CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .PCI_SELECT_STRAP(strap), .ETHERNET_ENABLE_STRAP(eth),
        .CLOCK_OUT_DIV_FOUR(pi.clk4), .CLOCK_OUT_DIV_SIX(pi.clk6), .VCXO_DAC_OUTPUT(pi.dac),
        .GPIO_PAD_I(pi.gpi), .GPIO_PAD_O(gpo), .GPIO_PAD_OE(gpoe),
        .PCI_SHARED_O(pi.pso), .PCI_SHARED_OE(pi.psoe), .PCI_SHARED_I(pci_i),
        .PCI_SOLO_CORE_O(pi.pco), .PCI_SOLO_CORE_OE(pi.pcoe),
        .PCI_SOLO_PAD_O(solo_o), .PCI_SOLO_PAD_OE(solo_oe),
        .VIDEO_PORT1_DATA_UP_O(pi.vuo), .VIDEO_PORT1_DATA_UP_OE(pi.vuoe),
        .VIDEO_PORT1_DATA_UP_I(vup_i), .AUDIO_SERIAL0_DATA_O(pi.auo),
        .AUDIO_SERIAL0_DATA_OE(pi.auoe), .AUDIO_SERIAL0_DATA_I(aud_i),
        .UPPER_PAD_I(pi.upi), .UPPER_PAD_O(up_o), .UPPER_PAD_OE(up_oe),
        .VIDEO_PORT1_DATA_LO_O(pi.vlo), .VIDEO_PORT1_DATA_LO_OE(pi.vloe),
        .VIDEO_PORT1_DATA_LO_I(vlo_i), .BUFFERED_SERIAL1_O(pi.sro),
        .BUFFERED_SERIAL1_OE(pi.sroe), .BUFFERED_SERIAL1_I(ser_i),
        .LOWER_PAD_I(pi.loi), .LOWER_PAD_O(lo_o), .LOWER_PAD_OE(lo_oe),
        .VIDEO_UPPER_SELECTED(sel_vu), .AUDIO_SELECTED(sel_au),
        .VIDEO_LOWER_SELECTED(sel_vl), .SERIAL_SELECTED(sel_sr)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ************************************************************
    // Reference model and checking
    // ************************************************************
    // Pad data is compared only where the enable is high: a released pad carries no meaning.
    function automatic logic [31:0] model(input logic [2:0] sel);
        logic [15:0] gm, o, oe;
        logic [7:0]  uo, uoe;
        logic [6:0]  lo, loe;
        logic        vid, aud, ser;
        logic [1:0]  uown, lown;
        vid = m_cfg[`CFG_VIDEO1_BIT];
        aud = !vid && m_cfg[`CFG_AUDIO0_BIT];
        ser = !vid && m_cfg[`CFG_SERIAL1_BIT];
        gm = m_en & (m_strap ? 16'h00FF : 16'hFFFF);
        oe = m_dir & gm;
        o = m_out;
        if (!gm[1]) {oe[1], o[1]} = {1'b1, pi.clk4};
        if (!gm[2]) {oe[2], o[2]} = {1'b1, pi.clk6};
        if (!gm[8]) {oe[8], o[8]} = {1'b1, pi.dac};
        if (m_strap) {oe[15:9], o[15:9]} = {pi.psoe, pi.pso};
        uoe = vid ? pi.vuoe : aud ? pi.auoe : 8'h00;
        uo = (vid ? pi.vuo : pi.auo) & uoe;
        loe = vid ? pi.vloe : ser ? pi.sroe : 7'h00;
        lo = (vid ? pi.vlo : pi.sro) & loe;
        uown = vid ? OWN_VIDEO : aud ? OWN_AUDIO : OWN_NONE;
        lown = vid ? OWN_VIDEO : ser ? OWN_SERIAL : OWN_NONE;
        case (sel)
            3'h1: return {oe, o & oe};
            3'h2: return m_strap ? {9'h000, pi.gpi[15:9], pi.pcoe, pi.pco & pi.pcoe} : 32'h0;
            3'h3: return {uoe, uo, vid ? pi.upi : 8'h00, aud ? pi.upi : 8'h00};
            3'h4: return {4'h0, loe, lo, vid ? pi.loi : 7'h00, ser ? pi.loi : 7'h00};
            3'h5: return {27'h0, vid, aud, vid, ser, 1'b0};
            3'h6: return {26'h0, lown, uown, m_eth, m_strap};
            default: return {16'h0000, pi.gpi & gm};
        endcase
    endfunction

    function automatic logic [31:0] seen(input logic [2:0] sel);
        case (sel)
            3'h1: return {gpoe, gpo & gpoe};
            3'h2: return {9'h000, pci_i, solo_oe, solo_o & solo_oe};
            3'h3: return {up_oe, up_o & up_oe, vup_i, aud_i};
            3'h4: return {4'h0, lo_oe, lo_o & lo_oe, vlo_i, ser_i};
            default: return {27'h0, sel_vu, sel_au, sel_vl, sel_sr, hresp};
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge clk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            rd_ph <= 1'b0;
            chk(hrdata, exq.size() ? exq.pop_front() : 32'hDEADBEEF);
        end
        if (hsel && htrans[1] && hreadyout === 1'b1) rd_ph <= !hwrite;
        if (probe != 3'h0) chk(seen(probe), exq.size() ? exq.pop_front() : 32'hDEADBEEF);
    end

    // ************************************************************
    // Drivers
    // ************************************************************
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exq.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask

    task automatic probe_chk(input logic [2:0] sel);
        @(posedge clk);
        exq.push_back(model(sel));
        probe <= sel;
        @(posedge clk);
        probe <= 3'h0;
    endtask

    task automatic rnd();
        @(posedge clk);
        {spare, pi} <= {$urandom, $urandom, $urandom, $urandom};
    endtask

    // The straps move right after release so a late change would show up as a wrong owner.
    task automatic do_reset(input logic s);
        logic e;
        e = 1'($urandom);
        @(posedge clk);
        rst <= 1'b1;
        strap <= s;
        eth <= e;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        strap <= !s;
        eth <= !e;
        {m_strap, m_eth, m_cfg} = {s, e, `CFG_RESET};
        {m_en, m_dir, m_out} = {`GP_RESET, `GP_RESET, `GP_RESET};
    endtask

    task automatic final_report();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("Error at %0t: run did not finish, got %h expected %h", $time, 0, 1);
        final_report();
    end

    initial begin
        {hsel, hwrite, strap, eth, haddr, hwdata, htrans, probe, spare, pi} = '0;
        rst = 1'b1;
        void'($urandom(32'h2CBC1B40));
        for (int s = 0; s < 2; s++) begin
            do_reset(s[0]);
            rnd();
            rd(`REG_PERIPH_CFG, 32'(`CFG_RESET));
            rd(`REG_GPIO_ENABLE, 32'(`GP_RESET));
            rd(`REG_STATUS, model(3'h6));
            for (int p = 1; p < 6; p++) probe_chk(3'(p));
            $display("Test reset defaults done, strap %0d", s);
            repeat (6) begin
                do_reset(s[0]);
                m_en = 16'($urandom);
                m_dir = 16'($urandom);
                m_out = 16'($urandom);
                wr(`REG_GPIO_ENABLE, {16'h0000, m_en});
                wr(`REG_GPIO_DIRECTION, {16'h0000, m_dir});
                wr(`REG_GPIO_OUT, {16'h0000, m_out});
                rnd();
                probe_chk(3'h1);
                probe_chk(3'h2);
                rd(`REG_GPIO_DIRECTION, {16'h0000, m_dir});
                rd(`REG_GPIO_IN, model(3'h7));
            end
            $display("Test general purpose pins done, strap %0d", s);
            for (int c = 0; c < 8; c++) begin
                do_reset(s[0]);
                m_cfg = 3'(c);
                wr(`REG_PERIPH_CFG, 32'(c));
                rnd();
                for (int p = 3; p < 6; p++) probe_chk(3'(p));
                rd(`REG_STATUS, model(3'h6));
            end
            $display("Test peripheral selection done, strap %0d", s);
            wr(`REG_STATUS, 32'hFFFFFFFF);
            wr(`REG_GPIO_IN, 32'hFFFFFFFF);
            wr(8'h40, 32'hFFFFFFFF);
            rd(8'h18, 32'h0);
            rd(`REG_STATUS, model(3'h6));
            rd(`REG_PERIPH_CFG, {29'h0, m_cfg});
            $display("Test refused accesses done, strap %0d", s);
        end
        final_report();
    end
endmodule // tb_top
